// ===== slu_barrel.sv
// Combinational logical shifter with last-bit-out capture on left shifts
`timescale 1ns/1ps
`default_nettype none
module slu_barrel #(
	parameter int W = 16
) (
	// Operand and amount
	input wire logic [W-1:0] data,
	input wire logic [5:0] amount,
	input wire logic toRight,
	// Results
	output logic [W-1:0] result,
	output logic carryOut
);
	// Double-width view holds the bit that last passed the high end
	logic [2*W-1:0] wide;

	// ==========================================
	// Shift network
	always_comb begin
		wide = {{W{1'b0}}, data} << amount;
		if (toRight) begin
			result = data >> amount;
			carryOut = 1'b0;
		end else begin
			result = wide[W-1:0];
			// Zero once the amount exceeds the width
			carryOut = wide[W];
		end
	end
endmodule
`default_nettype wire

// ===== slu_params.svh
// Offsets, field positions, reset values and status bits of the shift unit
`ifndef SLU_PARAMS_SVH
`define SLU_PARAMS_SVH

// ==========================================
// Register byte offsets on the APB slave
`define SLU_OFF_INSTR 8'h00
`define SLU_OFF_STATUS 8'h04
`define SLU_OFF_ACC 8'h08
`define SLU_OFF_EXT 8'h0C
`define SLU_OFF_IDX1 8'h10
`define SLU_OFF_IDX2 8'h14
`define SLU_OFF_IDX3 8'h18

// ==========================================
// Instruction word fields (bit 15 is the word's high-order end)
`define SLU_OP_HI 15
`define SLU_OP_LO 11
`define SLU_OP_LEFT 5'h02
`define SLU_OP_RIGHT 5'h03
`define SLU_FMT_BIT 10
`define SLU_TAG_HI 9
`define SLU_TAG_LO 8
`define SLU_MOD_DBL 7
`define SLU_MOD_CNT 6
`define SLU_CNT_HI 5

// ==========================================
// Status register bits and reset values
`define SLU_ST_BUSY 0
`define SLU_ST_CARRY 1
`define SLU_ST_OVFL 2
`define SLU_RST_WORD 16'h0000
`define SLU_RST_CNT 6'h00

`endif

// ===== slu_pkg.sv
// Types shared by the shift unit files
`default_nettype none
package slu_pkg;
	// Sequencer states of the unit
	typedef enum logic {
		ST_IDLE,
		ST_COUNT
	} slu_state_t;
	// Selector of the count source
	typedef logic [1:0] slu_tag_t;
endpackage
`default_nettype wire

// ===== slu_shift_unit.sv
// Shift execution unit with APB register access
// Contract
// - tag 11 counts from third index register
// - tags 00/01/10 pick displacement, index one, two
// - bit 7 selects double, bit 6 counting
// - zero plain count changes nothing
// - single left decoded from 1100..1300, 10[0-3]x
// - double left shifts 32 bits, zero fill
// - double left carry tracks last bit out
// - double left decoded 1180..1380, 10[8-B]x
// - counting single with tag 00 is plain
// - counter loads six bits, one per step
// - stop on leading one or count zero
// - remainder to bits 0-5, clear 6-7
// - zero count or leading one: no-op
// - carry clear on exhaustion, set on one
// - single counting decoded 1140..1340, 10[4-7]x
// - double counting feeds extension into accumulator
// - counting double with tag 00 is plain
// - double counting decoded 11C0..13C0, 10[C-F]x
// - right shift zero fills, extension kept
// - right shift decoded 1900..1B00, 18[0-3]x
`timescale 1ns/1ps
`default_nettype none
`include "slu_params.svh"
module slu_shift_unit (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Unit status
	output logic busy,
	output logic carryFlag,
	output var slu_pkg::slu_state_t unitState
);
	import slu_pkg::*;

	// ==========================================
	// State
	slu_state_t state, next_state;   // Sequencer
	logic [15:0] instr, next_instr;   // Last accepted instruction
	logic [15:0] acc, next_acc;   // Accumulator
	logic [15:0] ext, next_ext;   // Extension
	logic [15:0] idx1, next_idx1;   // First index register
	logic [15:0] idx2, next_idx2;   // Second index register
	logic [15:0] idx3, next_idx3;   // Third index register
	logic carry, next_carry;   // Carry indicator
	logic overflow, next_overflow;   // Overflow indicator, never shifted
	logic [5:0] cnt, next_cnt;   // Shift counter
	slu_tag_t cntSel, next_cntSel;   // Index register receiving remainder
	logic cntDbl, next_cntDbl;   // Counting covers extension too
	logic [31:0] next_prdata;   // Read data capture
	logic rdValid, next_rdValid;   // Read data captured while idle

	// ==========================================
	// Decode of the written instruction word
	logic accessDone;   // APB access completes this edge
	logic isLeft, isRight, modDbl, modCnt, fmtOk, legal;
	slu_tag_t wrTag;
	logic [5:0] srcCount;   // Effective count of written word
	logic [15:0] sRes;
	logic [31:0] dRes;
	logic sCarry, dCarry;
	logic [15:0] selXr;   // Index register under counting
	logic [15:0] readMux;
	logic mapped;

	assign isLeft = pwdata[`SLU_OP_HI:`SLU_OP_LO] == `SLU_OP_LEFT;
	assign isRight = pwdata[`SLU_OP_HI:`SLU_OP_LO] == `SLU_OP_RIGHT;
	assign modDbl = pwdata[`SLU_MOD_DBL];
	assign modCnt = pwdata[`SLU_MOD_CNT];
	assign fmtOk = !pwdata[`SLU_FMT_BIT];
	assign wrTag = pwdata[`SLU_TAG_HI:`SLU_TAG_LO];
	// Right shift only in its plain single form here
	assign legal = fmtOk && (isLeft || (isRight && !modDbl && !modCnt));
	assign busy = state != ST_IDLE;
	assign unitState = state;
	assign carryFlag = carry;
	// Writes complete at once while idle; reads wait one captured cycle; both wait while busy
	assign pready = !busy && (pwrite || rdValid);
	assign accessDone = psel && penable && pready;
	assign mapped = paddr == `SLU_OFF_INSTR || paddr == `SLU_OFF_STATUS
		|| paddr == `SLU_OFF_ACC || paddr == `SLU_OFF_EXT
		|| paddr == `SLU_OFF_IDX1 || paddr == `SLU_OFF_IDX2 || paddr == `SLU_OFF_IDX3;
	// Unmapped address or unsupported instruction answers with an error
	assign pslverr = accessDone
		&& (!mapped || (pwrite && paddr == `SLU_OFF_INSTR && !legal));

	// Count source selection
	always_comb begin
		case (wrTag)
			2'b00: srcCount = pwdata[`SLU_CNT_HI:0];
			2'b01: srcCount = idx1[`SLU_CNT_HI:0];
			2'b10: srcCount = idx2[`SLU_CNT_HI:0];
			default: srcCount = idx3[`SLU_CNT_HI:0];
		endcase
	end

	// Remainder destination
	always_comb begin
		case (cntSel)
			2'b01: selXr = idx1;
			2'b10: selXr = idx2;
			default: selXr = idx3;
		endcase
	end

	// ==========================================
	// Shifters for the one-step plain forms
	slu_barrel #(.W(16)) uSingle (
		.data(acc),
		.amount(srcCount),
		.toRight(isRight),
		.result(sRes),
		.carryOut(sCarry)
	);

	slu_barrel #(.W(32)) uDouble (
		.data({acc, ext}),
		.amount(srcCount),
		.toRight(1'b0),
		.result(dRes),
		.carryOut(dCarry)
	);

	// Read multiplexer
	always_comb begin
		if (paddr == `SLU_OFF_INSTR) begin
			readMux = instr;
		end else if (paddr == `SLU_OFF_STATUS) begin
			readMux = {13'h0000, overflow, carry, busy};
		end else if (paddr == `SLU_OFF_ACC) begin
			readMux = acc;
		end else if (paddr == `SLU_OFF_EXT) begin
			readMux = ext;
		end else if (paddr == `SLU_OFF_IDX1) begin
			readMux = idx1;
		end else if (paddr == `SLU_OFF_IDX2) begin
			readMux = idx2;
		end else if (paddr == `SLU_OFF_IDX3) begin
			readMux = idx3;
		end else begin
			readMux = 16'h0000;
		end
	end

	// ==========================================
	// Next-state logic: bus writes, plain shifts, counting steps
	always_comb begin
		logic fin;
		logic [5:0] rem;
		fin = 1'b0;
		rem = cnt;
		next_state = state;
		next_instr = instr;
		next_acc = acc;
		next_ext = ext;
		next_idx1 = idx1;
		next_idx2 = idx2;
		next_idx3 = idx3;
		next_carry = carry;
		next_overflow = overflow;
		next_cnt = cnt;
		next_cntSel = cntSel;
		next_cntDbl = cntDbl;
		next_prdata = prdata;
		// Capture read data only while idle
		next_rdValid = psel && !busy && !accessDone && !pwrite;
		if (psel && !busy) begin
			next_prdata = {16'h0000, readMux};
		end
		if (accessDone && pwrite) begin
			if (paddr == `SLU_OFF_INSTR && legal) begin
				next_instr = pwdata[15:0];
				if (isLeft && modCnt && wrTag != 2'b00) begin
					// Counting form, skipped on zero count or leading one
					if (srcCount != 6'h00 && !acc[15]) begin
						next_state = ST_COUNT;
						next_cnt = srcCount;
						next_cntSel = wrTag;
						next_cntDbl = modDbl;
					end
				end else if (srcCount != 6'h00) begin
					if (isRight) begin
						next_acc = sRes;
					end else if (modDbl) begin
						// Tag 00 counting double lands here too
						next_acc = dRes[31:16];
						next_ext = dRes[15:0];
						next_carry = dCarry;
					end else begin
						next_acc = sRes;
						next_carry = sCarry;
					end
				end
			end else if (paddr == `SLU_OFF_STATUS) begin
				next_carry = pwdata[`SLU_ST_CARRY];
				next_overflow = pwdata[`SLU_ST_OVFL];
			end else if (paddr == `SLU_OFF_ACC) begin
				next_acc = pwdata[15:0];
			end else if (paddr == `SLU_OFF_EXT) begin
				next_ext = pwdata[15:0];
			end else if (paddr == `SLU_OFF_IDX1) begin
				next_idx1 = pwdata[15:0];
			end else if (paddr == `SLU_OFF_IDX2) begin
				next_idx2 = pwdata[15:0];
			end else if (paddr == `SLU_OFF_IDX3) begin
				next_idx3 = pwdata[15:0];
			end
		end
		case (state)
			ST_COUNT: begin
				if (acc[15]) begin
					// Leading one stays in place
					fin = 1'b1;
					next_carry = 1'b1;
				end else begin
					if (cntDbl) begin
						{next_acc, next_ext} = {acc[14:0], ext, 1'b0};
					end else begin
						next_acc = {acc[14:0], 1'b0};
					end
					rem = cnt - 6'h01;
					next_cnt = rem;
					if (cnt == 6'h01) begin
						fin = 1'b1;
						next_carry = 1'b0;
					end
				end
				if (fin) begin
					next_state = ST_IDLE;
					// Remainder low six bits, two above cleared
					case (cntSel)
						2'b01: next_idx1 = {idx1[15:8], 2'b00, rem};
						2'b10: next_idx2 = {idx2[15:8], 2'b00, rem};
						default: next_idx3 = {idx3[15:8], 2'b00, rem};
					endcase
				end
			end
			default: begin
				// Idle: only a bus write above moves the sequencer
			end
		endcase
	end

	// Register update
	always_ff @(posedge core_clk) begin
		if (reset) begin
			state <= ST_IDLE;
			instr <= `SLU_RST_WORD;
			acc <= `SLU_RST_WORD;
			ext <= `SLU_RST_WORD;
			idx1 <= `SLU_RST_WORD;
			idx2 <= `SLU_RST_WORD;
			idx3 <= `SLU_RST_WORD;
			carry <= 1'b0;
			overflow <= 1'b0;
			cnt <= `SLU_RST_CNT;
			cntSel <= 2'b00;
			cntDbl <= 1'b0;
			prdata <= 32'h00000000;
			rdValid <= 1'b0;
		end else begin
			state <= next_state;
			instr <= next_instr;
			acc <= next_acc;
			ext <= next_ext;
			idx1 <= next_idx1;
			idx2 <= next_idx2;
			idx3 <= next_idx3;
			carry <= next_carry;
			overflow <= next_overflow;
			cnt <= next_cnt;
			cntSel <= next_cntSel;
			cntDbl <= next_cntDbl;
			prdata <= next_prdata;
			rdValid <= next_rdValid;
		end
	end

	// ==========================================
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	logic instrWr;   // Legal instruction taken this edge
	assign instrWr = accessDone && pwrite && paddr == `SLU_OFF_INSTR && legal && !busy;

	sequence sqCountEnd;
		state == ST_COUNT ##1 state == ST_IDLE;
	endsequence

	AST_SINGLE_LEFT: assert property (instrWr && isLeft && !modDbl && !modCnt && wrTag == 2'b00 |=>
		acc == ($past(acc) << $past(pwdata[5:0])) && ext == $past(ext))
		else $error("single left shift result wrong");
	AST_THIRD_XR: assert property (instrWr && isRight && wrTag == 2'b11 |=>
		acc == ($past(acc) >> $past(idx3[5:0])))
		else $error("third index count not used");
	AST_ZERO_NOP: assert property (instrWr && !(isLeft && modCnt && wrTag != 2'b00)
		&& srcCount == 6'h00 |=> $stable(acc) && $stable(ext) && $stable(carry))
		else $error("zero count changed state");
	AST_DBL_CARRY: assert property (instrWr && isLeft && modDbl && !modCnt && srcCount == 6'h01
		|=> carry == $past(acc[15]) && acc[0] == $past(ext[15]) && ext[0] == 1'b0)
		else $error("double shift carry wrong");
	AST_RIGHT_EXT: assert property (instrWr && isRight |=> $stable(ext) && $stable(carry))
		else $error("right shift touched extension");
	AST_COUNT_NOP: assert property (instrWr && isLeft && modCnt && wrTag != 2'b00
		&& (srcCount == 6'h00 || acc[15]) |=> state == ST_IDLE && $stable(acc))
		else $error("counting no-op did work");
	AST_COUNT_ONE: assert property (state == ST_COUNT && acc[15] |=>
		state == ST_IDLE && carry && acc[15])
		else $error("leading one stop wrong");
	AST_COUNT_ZERO: assert property (state == ST_COUNT && !acc[15] && cnt == 6'h01 |=>
		state == ST_IDLE && !carry && cnt == 6'h00)
		else $error("exhaustion stop wrong");
	AST_REMAINDER: assert property (sqCountEnd |-> selXr[7:6] == 2'b00
		&& selXr[5:0] == cnt && selXr[15:8] == $past(selXr[15:8]))
		else $error("remainder write-back wrong");
	AST_DBL_FEED: assert property (state == ST_COUNT && cntDbl && !acc[15] |=>
		acc[0] == $past(ext[15]) && ext[0] == 1'b0)
		else $error("extension not fed into accumulator");
endmodule
`default_nettype wire

// ===== slu_shift_unit_test.sv
// Self-checking testbench of the shift unit through its APB registers
`timescale 1ns/1ps
`default_nettype none
`include "slu_params.svh"
module slu_shift_unit_test;
	import slu_pkg::*;
	// ==========================================
	// Stimulus and observed signals
	logic core_clk = 1'h0;
	logic reset = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, busy, carryFlag;
	slu_state_t unitState;
	int errorCnt = 0;
	int nCompared = 0;
	logic [15:0] lastIns = 16'h0; // Last accepted instruction word
	logic [7:0] offs [7] = '{`SLU_OFF_INSTR, `SLU_OFF_STATUS, `SLU_OFF_ACC, `SLU_OFF_EXT,
		`SLU_OFF_IDX1, `SLU_OFF_IDX2, `SLU_OFF_IDX3};

	slu_shift_unit u_slu_shift_unit (.core_clk(core_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .busy(busy), .carryFlag(carryFlag),
		.unitState(unitState));

	// 40 MHz clock
	always #12.5 core_clk = ~core_clk;

	// ==========================================
	// Comparison with counting
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			errorCnt++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge core_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		n = 0;
		// Answer is taken at the rising edge itself, before the registers move
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'h1 && n < 200);
		chk("pready wait", {31'h0, pready}, 32'h1);
		rd = prdata;
		er = pslverr;
		// Released at the completing edge; next call waits one edge first
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// Preset registers, execute, model the result, read everything back
	task automatic run(input logic [15:0] ins, a, q, x1, x2, x3, input logic [1:0] st);
		logic [15:0] x [4];
		logic [15:0] ex [7];
		logic [5:0] n;
		logic [31:0] r;
		logic e, ee, c, one, cnt;
		int k;
		x = '{{10'h0, ins[5:0]}, x1, x2, x3};
		n = x[ins[9:8]][5:0];
		c = st[0];
		one = 1'h0;
		cnt = ins[6] && ins[9:8] != 2'h0;
		ee = !(ins[15:11] inside {5'h02, 5'h03}) || ins[10] || (ins[15:11] == 5'h03 && ins[7:6] != 2'h0);
		ex = '{16'h0, {13'h0, st, 1'h0}, a, q, x1, x2, x3};
		for (k = 1; k < 7; k++)
			apb(1'h1, offs[k], {16'h0, ex[k]}, r, e);
		apb(1'h1, `SLU_OFF_INSTR, {16'h0, ins}, r, e);
		chk("refusal", {31'h0, e}, {31'h0, ee});
		// A counting run that really shifts must show busy
		if (!ee && cnt && n != 6'h0 && !a[15]) begin
			@(negedge core_clk);
			chk("busy", {31'h0, busy}, 32'h1);
			chk("state", {31'h0, unitState}, {31'h0, ST_COUNT});
		end
		k = 0;
		while (busy !== 1'h0 && k < 80) begin
			@(negedge core_clk);
			k++;
		end
		chk("busy end", {31'h0, busy}, 32'h0);
		// Reference behaviour
		if (!ee && ins[15:11] == 5'h03)
			a = a >> n;
		else if (!ee && !cnt)
			repeat (n) begin
				c = a[15];
				if (ins[7])
					{a, q} = {a, q} << 1;
				else
					a = a << 1;
			end
		else if (!ee && n != 6'h0 && !a[15]) begin
			while (n != 6'h0 && !one) begin
				if (a[15])
					one = 1'h1;
				else begin
					if (ins[7])
						{a, q} = {a, q} << 1;
					else
						a = a << 1;
					n--;
				end
			end
			c = one;
			x[ins[9:8]] = {x[ins[9:8]][15:8], 2'h0, n};
		end
		if (!ee)
			lastIns = ins;
		ex = '{lastIns, {13'h0, st[1], c, 1'h0}, a, q, x[1], x[2], x[3]};
		for (k = 0; k < 7; k++) begin
			apb(1'h0, offs[k], 32'h0, r, e);
			chk($sformatf("reg %h", offs[k]), r, {16'h0, ex[k]});
		end
		chk("carry pin", {31'h0, carryFlag}, {31'h0, c});
		$display("test %h done", ins);
	endtask

	// Verdict and end of run
	task conclude();
		$display("compared %0d mismatches %0d", nCompared, errorCnt);
		if (errorCnt == 0 && nCompared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (40000) @(posedge core_clk);
		errorCnt++;
		conclude();
	end

	// ==========================================
	// Test sequence
	initial begin
		logic [31:0] r;
		logic e;
		repeat (16) @(posedge core_clk);
		reset <= 1'h0;
		for (int k = 0; k < 7; k++) begin
			apb(1'h0, offs[k], 32'h0, r, e);
			chk("reset value", r, 32'h0);
		end
		apb(1'h1, 8'h1C, 32'h0000FFFF, r, e);
		chk("unmapped write", {31'h0, e}, 32'h1);
		apb(1'h0, 8'h1C, 32'h0, r, e);
		chk("unmapped read", {e, r[30:0]}, 32'h80000000);
		$display("reset and address map test done");
		run(16'h1003, 16'hF00F, 16'h1234, 16'h0, 16'h0, 16'h0, 2'h0);
		run(16'h1000, 16'h5555, 16'h1234, 16'h0, 16'h0, 16'h0, 2'h3);
		run(16'h1100, 16'h7FFF, 16'h0, 16'hFF11, 16'h0, 16'h0, 2'h2);
		run(16'h1200, 16'hC3A5, 16'h0, 16'h0, 16'h0005, 16'h0, 2'h0);
		run(16'h1300, 16'h8001, 16'h0, 16'h0, 16'h0, 16'hFFC1, 2'h0);
		run(16'h1084, 16'h1234, 16'hABCD, 16'h0, 16'h0, 16'h0, 2'h2);
		run(16'h10B0, 16'hFFFF, 16'hFFFF, 16'h0, 16'h0, 16'h0, 2'h0);
		run(16'h1180, 16'h0001, 16'h8000, 16'h000F, 16'h0, 16'h0, 2'h1);
		run(16'h1280, 16'hFFFF, 16'h0001, 16'h0, 16'h0020, 16'h0, 2'h0);
		run(16'h1380, 16'h8000, 16'h0001, 16'h0, 16'h0, 16'h0001, 2'h0);
		run(16'h1042, 16'h4001, 16'h0, 16'h0, 16'h0, 16'h0, 2'h0);
		run(16'h1140, 16'h0800, 16'h0, 16'hA5C5, 16'h0, 16'h0, 2'h0);
		run(16'h1140, 16'h0800, 16'h0, 16'h0004, 16'h0, 16'h0, 2'h1);
		run(16'h1240, 16'h0800, 16'h0, 16'h0, 16'h0003, 16'h0, 2'h3);
		run(16'h1340, 16'h0800, 16'h0, 16'h0, 16'h0, 16'hFF00, 2'h1);
		run(16'h1140, 16'h8001, 16'h0, 16'h0007, 16'h0, 16'h0, 2'h0);
		run(16'h10C3, 16'hE000, 16'h0001, 16'h0, 16'h0, 16'h0, 2'h0);
		run(16'h11C0, 16'h0, 16'h0100, 16'h0014, 16'h0, 16'h0, 2'h0);
		run(16'h12C0, 16'h0, 16'h0001, 16'h0, 16'h12E8, 16'h0, 2'h2);
		run(16'h13C0, 16'h0, 16'h4000, 16'h0, 16'h0, 16'h0002, 2'h3);
		run(16'h1805, 16'h8421, 16'h5A5A, 16'h0, 16'h0, 16'h0, 2'h1);
		run(16'h1900, 16'hFFFF, 16'h1234, 16'h0010, 16'h0, 16'h0, 2'h0);
		run(16'h1A00, 16'hF0F0, 16'h0, 16'h0, 16'h0004, 16'h0, 2'h0);
		run(16'h1B00, 16'h1234, 16'h0, 16'h0, 16'h0, 16'h0, 2'h2);
		run(16'h1400, 16'h1111, 16'h0, 16'h0, 16'h0, 16'h0, 2'h0);
		run(16'h1840, 16'h2222, 16'h0, 16'h0, 16'h0, 16'h0, 2'h0);
		conclude();
	end
endmodule
`default_nettype wire
